// file: src/cis_pkg.sv
// Overview of operation
// - hold hardware requests until instruction completes
// - service only when unmasked and, for timer and port sources, enabled
// - external request wins over timer request
// - software trap ignores the interrupt mask
// - entry pushes five bytes then sets mask
// - return from trap pulls and restores registers
// - fixed vector pairs for reset, trap, external
// - three enabled timer flags share one vector
// - reset pin sets mask, loads reset vector
// - masked external requests stay latched until unmasked
// - oscillator halt sleeps until external or reset
// - clock pause wakes on reset, external, timer
// - falling edge latch, synchronised to core clock
// - edge-only option ignores static pin level
// - level option also requests while pins low
// - pin and enabled port sources ORed together
// - external latch clears on entering its service
// - stack pointer resets to 00FF, push decrements
// - stack address is 0000011 plus six bits
// - subroutine call pushes exactly two bytes
// - program counter is thirteen bits wide
// - output-configured port pins never raise requests
// - low-power instructions clear the interrupt mask
package cis_pkg;
    // ****************************************
    // register map and fields
    // ****************************************
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;  // control, read/write
    localparam logic [7:0]  ADDR_STAT   = 8'h04;  // status, read only
    localparam int          CTRL_TEN    = 0;      // timer enables [2:0]
    localparam int          CTRL_EDGE   = 3;      // edge-only sensing
    localparam int          CTRL_PAEN   = 8;      // port source enables [15:8]
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam int          STAT_EXT    = 0;      // external latch
    localparam int          STAT_TMR    = 1;      // timer request
    localparam int          STAT_MASK   = 2;      // interrupt mask
    localparam int          STAT_SLEEP  = 3;      // asleep
    localparam int          STAT_SP     = 8;      // stack pointer [13:8]
    // ****************************************
    // vectors, stack and frame
    // ****************************************
    localparam logic [12:0] VEC_RESET   = 13'h1FFE;
    localparam logic [12:0] VEC_TRAP    = 13'h1FFC;
    localparam logic [12:0] VEC_EXT     = 13'h1FFA;
    localparam logic [12:0] VEC_TMR     = 13'h1FF8;
    localparam logic [6:0]  STACK_HI    = 7'h03;  // 0000011
    localparam logic [5:0]  SP_RESET    = 6'h3F;  // 00FF
    localparam logic [2:0]  FRAME_LEN   = 3'h5;
    localparam logic [2:0]  CALL_LEN    = 3'h2;
    localparam logic [2:0]  VEC_LEN     = 3'h2;
    localparam int          CCR_I       = 3;      // mask bit in stacked byte
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        OP_NONE, OP_TRAP, OP_RTI, OP_CALL, OP_RET,
        OP_RSP, OP_HALT, OP_PAUSE, OP_CLI, OP_SEI
    } cis_op_t;
    typedef enum logic [7:0] {
        ST_RUN  = 8'h01, ST_PUSH = 8'h02, ST_CALL = 8'h04,
        ST_VEC  = 8'h08, ST_PULL = 8'h10, ST_RET  = 8'h20,
        ST_STOP = 8'h40, ST_WAIT = 8'h80
    } cis_state_t;
    typedef struct packed {
        logic        done;     // instruction completed
        cis_op_t     op;       // which instruction completed
        logic [12:0] pc_next;  // address after it
        logic [12:0] target;   // call destination
        logic [7:0]  acc;
        logic [7:0]  idx;
        logic [3:0]  hnzc;     // flags other than the mask
    } cis_core_t;
    typedef struct packed {
        logic        valid;    // one-cycle restore pulse
        logic [7:0]  acc;
        logic [7:0]  idx;
        logic [3:0]  hnzc;
    } cis_restore_t;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [12:0] addr;
        logic [7:0]  wdata;
    } cis_mem_t;
endpackage : cis_pkg

// file: src/cis_top.sv
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cis_top (
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  reset_in,
    // pins
    input  wire logic                  reset_pin_n_in,
    input  wire logic                  irq_n_in,
    input  wire logic [7:0]            port_a_in,
    input  wire logic [7:0]            port_a_dir_in,
    input  wire logic [2:0]            timer_flags_in,
    // core side
    input  wire cis_pkg::cis_core_t    core_in,
    output logic                       busy_out,
    output logic                       mask_out,
    output logic [12:0]                pc_out,
    output cis_pkg::cis_restore_t      restore_out,
    output logic                       osc_off_out,
    output logic                       clocks_off_out,
    // stack and vector memory
    output cis_pkg::cis_mem_t          mem_out,
    input  wire logic [7:0]            mem_rdata_in,
    // ahb-lite slave
    input  wire logic                  hsel_in,
    input  wire logic [31:0]           haddr_in,
    input  wire logic [1:0]            htrans_in,
    input  wire logic                  hwrite_in,
    input  wire logic [2:0]            hsize_in,
    input  wire logic [31:0]           hwdata_in,
    input  wire logic                  hready_in,
    output logic                       hreadyout_out,
    output logic                       hresp_out,
    output logic [31:0]                hrdata_out
);
    import cis_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    cis_state_t  state;          // sequencer state
    logic [2:0]  cnt;            // byte step within a state
    logic [5:0]  sp;             // stack pointer low bits
    logic [12:0] pc;             // program counter
    logic        imask;          // interrupt mask
    logic [12:0] vec;            // selected vector pair
    logic [12:0] tgt;            // saved call target
    logic [7:0]  pbuf [0:4];     // pulled bytes
    logic        rd_q;           // read issued last cycle
    logic [2:0]  idx_q;          // its byte index
    logic [31:0] ctrl;           // control register
    logic [1:0]  rp_s, irq_s;    // pin synchronisers
    logic [7:0]  pa_s1, pa_s2;   // port synchroniser
    logic        low_q;          // last OR term value
    logic        ext_latch;      // edge-detect latch
    logic        ext_req;        // external request
    logic        tmr_req;        // timer request
    logic        or_low;         // combined active-low term
    logic        hw_go;          // unmasked hardware request
    logic        ext_ack;        // entering external service
    logic        pin_rst;        // reset pin asserted
    logic [2:0]  rd_n;           // reads in this state
    logic        ap_wr;          // registered write address phase
    logic [7:0]  ap_addr;
    logic [7:0]  ccr_byte;       // stacked flags

    // ****************************************
    // pin synchronisers
    // ****************************************
    // two flops each; only the second stage is read anywhere
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rp_s  <= 2'h3;
            irq_s <= 2'h3;
            pa_s1 <= 8'hFF;
            pa_s2 <= 8'hFF;
        end else begin
            rp_s  <= {rp_s[0], reset_pin_n_in};
            irq_s <= {irq_s[0], irq_n_in};
            pa_s1 <= port_a_in;
            pa_s2 <= pa_s1;
        end
    end
    assign pin_rst = ~rp_s[1];

    // ****************************************
    // external request logic
    // ****************************************
    // pin and enabled input-direction port bits form one low term
    assign or_low = ~irq_s[1]
                  | |(~pa_s2 & ctrl[CTRL_PAEN +: 8] & ~port_a_dir_in);
    // level sensing adds the live term; edge-only uses the latch alone
    assign ext_req = ext_latch | (~ctrl[CTRL_EDGE] & or_low);
    assign tmr_req = |(timer_flags_in & ctrl[CTRL_TEN +: 3]);
    assign ext_ack = (state == ST_VEC) && (cnt == VEC_LEN + 3'h1) && (vec == VEC_EXT);

    // edge latch: a new edge in the ack cycle survives (set wins)
    // note: the edge is seen after synchronising, so pulses shorter
    // than a clock period may be missed
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            low_q     <= 1'b0;
            ext_latch <= 1'b0;
        end else begin
            low_q <= or_low;
            if (or_low && !low_q) begin
                ext_latch <= 1'b1;
            end else if (ext_ack) begin
                ext_latch <= 1'b0;
            end
        end
    end
    // requests act at a completed instruction or in clock pause, and only when unmasked; oscillator halt wakes on ext_req alone
    assign hw_go = ~imask & (ext_req | tmr_req);

    // ****************************************
    // memory port
    // ****************************************
    always_comb begin
        unique case (state)
            ST_VEC:  rd_n = VEC_LEN;
            ST_PULL: rd_n = FRAME_LEN;
            ST_RET:  rd_n = CALL_LEN;
            default: rd_n = 3'h0;
        endcase
    end
    assign ccr_byte = {3'h7, core_in.hnzc[3], imask, core_in.hnzc[2:0]};

    // strobes follow state directly so a read lands next cycle
    always_comb begin
        mem_out.rd    = (cnt < rd_n);
        mem_out.wr    = (state == ST_PUSH) || (state == ST_CALL);
        if (state == ST_VEC) begin
            mem_out.addr = vec + {10'h000, cnt};
        end else if (mem_out.wr) begin
            mem_out.addr = {STACK_HI, sp};
        end else begin
            mem_out.addr = {STACK_HI, 6'(sp + 6'h01)};
        end
        unique case (cnt)
            3'h0:    mem_out.wdata = pc[7:0];
            3'h1:    mem_out.wdata = {3'h0, pc[12:8]};
            3'h2:    mem_out.wdata = core_in.idx;
            3'h3:    mem_out.wdata = core_in.acc;
            default: mem_out.wdata = ccr_byte;
        endcase
    end

    // capture read data one cycle after the strobe
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rd_q  <= 1'b0;
            idx_q <= 3'h0;
        end else begin
            rd_q  <= mem_out.rd;
            idx_q <= cnt;
        end
    end
    always_ff @(posedge clock_in) begin
        if (rd_q) begin
            pbuf[idx_q] <= mem_rdata_in;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    // the core stalls while busy, so acc and idx stay put during a push
    always_ff @(posedge clock_in) begin
        restore_out.valid <= 1'b0;
        if (reset_in || pin_rst) begin
            state <= ST_VEC;
            vec   <= VEC_RESET;
            cnt   <= 3'h0;
            sp    <= SP_RESET;
            imask <= 1'b1;
            pc    <= 13'h0000;
            tgt   <= 13'h0000;
            restore_out <= '0;
        end else begin
            unique case (state)
                ST_RUN: begin
                    cnt <= 3'h0;
                    if (core_in.done) begin
                        pc <= core_in.pc_next;
                        unique case (core_in.op)
                            OP_TRAP: begin
                                state <= ST_PUSH;
                                vec   <= VEC_TRAP;
                            end
                            OP_RTI:   state <= ST_PULL;
                            OP_CALL: begin
                                state <= ST_CALL;
                                tgt   <= core_in.target;
                            end
                            OP_RET:   state <= ST_RET;
                            OP_HALT: begin
                                state <= ST_STOP;
                                imask <= 1'b0;
                            end
                            OP_PAUSE: begin
                                state <= ST_WAIT;
                                imask <= 1'b0;
                            end
                            OP_CLI:   imask <= 1'b0;
                            OP_SEI:   imask <= 1'b1;
                            default: begin
                                if (core_in.op == OP_RSP) sp <= SP_RESET;
                                if (hw_go) begin
                                    state <= ST_PUSH;
                                    vec   <= ext_req ? VEC_EXT : VEC_TMR;
                                end
                            end
                        endcase
                    end
                end
                ST_PUSH: begin
                    sp  <= sp - 6'h01;
                    cnt <= cnt + 3'h1;
                    if (cnt == FRAME_LEN - 3'h1) begin
                        imask <= 1'b1;
                        state <= ST_VEC;
                        cnt   <= 3'h0;
                    end
                end
                ST_CALL: begin
                    sp  <= sp - 6'h01;
                    cnt <= cnt + 3'h1;
                    if (cnt == CALL_LEN - 3'h1) begin
                        pc    <= tgt;
                        state <= ST_RUN;
                    end
                end
                ST_VEC: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == VEC_LEN + 3'h1) begin
                        pc    <= {pbuf[0][4:0], pbuf[1]};
                        state <= ST_RUN;
                    end
                end
                ST_PULL: begin
                    cnt <= cnt + 3'h1;
                    if (cnt < FRAME_LEN) begin
                        sp <= sp + 6'h01;
                    end
                    if (cnt == FRAME_LEN + 3'h1) begin
                        imask <= pbuf[0][CCR_I];
                        restore_out.valid <= 1'b1;
                        restore_out.hnzc  <= {pbuf[0][4], pbuf[0][2:0]};
                        restore_out.acc   <= pbuf[1];
                        restore_out.idx   <= pbuf[2];
                        pc    <= {pbuf[3][4:0], pbuf[4]};
                        state <= ST_RUN;
                    end
                end
                ST_RET: begin
                    cnt <= cnt + 3'h1;
                    if (cnt < CALL_LEN) begin
                        sp <= sp + 6'h01;
                    end
                    if (cnt == CALL_LEN + 3'h1) begin
                        pc    <= {pbuf[0][4:0], pbuf[1]};
                        state <= ST_RUN;
                    end
                end
                ST_STOP: begin
                    // oscillator off: only the external request wakes; cnt is still zero
                    if (ext_req) begin
                        state <= ST_PUSH;
                        vec   <= VEC_EXT;
                    end
                end
                ST_WAIT: begin
                    // timer keeps running, so its request also wakes; cnt is still zero
                    if (hw_go) begin
                        state <= ST_PUSH;
                        vec   <= ext_req ? VEC_EXT : VEC_TMR;
                    end
                end
            endcase
        end
    end

    assign busy_out       = (state != ST_RUN);
    assign mask_out       = imask;
    assign pc_out         = pc;
    assign osc_off_out    = (state == ST_STOP);
    assign clocks_off_out = (state == ST_WAIT);

    // ****************************************
    // ahb-lite register slave
    // ****************************************
    // zero wait states, always okay; unmapped reads return zero
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ap_wr   <= 1'b0;
            ap_addr <= 8'h00;
        end else if (hready_in) begin
            ap_wr   <= hsel_in && htrans_in[1] && hwrite_in;
            ap_addr <= haddr_in[7:0];
        end
    end

    // control register written in the data phase
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ctrl <= CTRL_RESET;
        end else if (ap_wr && ap_addr == ADDR_CTRL) begin
            ctrl <= {16'h0000, hwdata_in[15:8], 4'h0, hwdata_in[3:0]};
        end
    end

    // read data registered at the address phase
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
            hrdata_out <= 32'h0000_0000;
            if (haddr_in[7:0] == ADDR_CTRL) begin
                hrdata_out <= ctrl;
            end else if (haddr_in[7:0] == ADDR_STAT) begin
                hrdata_out[STAT_EXT]       <= ext_latch;
                hrdata_out[STAT_TMR]       <= tmr_req;
                hrdata_out[STAT_MASK]      <= imask;
                hrdata_out[STAT_SLEEP]     <= osc_off_out | clocks_off_out;
                hrdata_out[STAT_SP +: 6]   <= sp;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in || pin_rst);
    push_sets_mask_a: assert property (
        (state == ST_PUSH && cnt == 3'h0) |-> ##5 (state == ST_VEC && imask))
        else $error("frame push not five bytes or mask not set");
    call_two_a: assert property (
        (state == ST_CALL && cnt == 3'h0) |-> ##2 (state == ST_RUN))
        else $error("call push not two bytes");
    ext_first_a: assert property (
        (state == ST_RUN && core_in.done && core_in.op == OP_NONE && hw_go && ext_req)
        |=> (state == ST_PUSH && vec == VEC_EXT))
        else $error("external request not served first");
    masked_hold_a: assert property (
        (state == ST_RUN && core_in.done && core_in.op == OP_NONE && imask)
        |=> (state == ST_RUN))
        else $error("masked request was taken");
    trap_unmasked_a: assert property (
        (state == ST_RUN && core_in.done && core_in.op == OP_TRAP)
        |=> (state == ST_PUSH && vec == VEC_TRAP))
        else $error("trap not taken");
    stack_window_a: assert property (
        mem_out.wr |-> (mem_out.addr[12:6] == STACK_HI && mem_out.addr[5:0] == sp))
        else $error("stack write outside window");
    push_decrement_a: assert property (
        mem_out.wr |=> (sp == $past(sp) - 6'h01))
        else $error("stack pointer did not decrement");
    edge_only_a: assert property (
        (ctrl[CTRL_EDGE] && !ext_latch) |-> !ext_req)
        else $error("level request in edge-only mode");
    ext_clear_a: assert property (
        (ext_ack && !(or_low && !low_q)) |=> !ext_latch)
        else $error("external latch not cleared");
    sleep_unmask_a: assert property (
        (state == ST_RUN && core_in.done && core_in.op == OP_HALT)
        |=> (state == ST_STOP && !imask))
        else $error("halt did not clear mask");
endmodule : cis_top

// file: testbench/cis_mem_model.sv
`timescale 1ns/1ps
module cis_mem_model (
    // clock
    input  wire logic             clock_in,
    // stack and vector requests
    input  wire cis_pkg::cis_mem_t mem_in,
    output logic [7:0]            rdata_out
);
    import cis_pkg::*;
    logic [7:0] mem [0:8191]; // the whole 8 Kbyte space
    // ****************************************
    // contents
    // ****************************************
    // every pair reads high byte 05 first, low byte equal to its own address
    initial begin
        rdata_out = 8'h00;
        for (int a = 0; a < 8192; a++) begin
            mem[a] = a[0] ? a[7:0] : 8'h05;
        end
    end
    // sync ram; idle cycles show the inverse so stale data cannot pass
    always @(posedge clock_in) begin
        if (mem_in.wr) begin
            mem[mem_in.addr] <= mem_in.wdata;
        end
        rdata_out <= mem_in.rd ? mem[mem_in.addr] : ~rdata_out;
    end
endmodule : cis_mem_model

// file: testbench/cpu_interrupt_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module cpu_interrupt_sequencer_tb_top;
    import cis_pkg::*;
    logic clk, rst, rpin, irq_n, hsel, hwr, hrdy, hresp, busy, mask, oscoff, clkoff;
    logic [7:0]  pa, pdir, rdata;
    logic [2:0]  tflag;
    logic [1:0]  htrans;
    logic [12:0] pc;
    logic [31:0] haddr, hwdata, hrdata, rd;
    cis_core_t   core;
    cis_mem_t    mem;
    cis_restore_t restore;
    int          n_mismatch;
    int          check_count;
    cis_top u_dut (.clock_in(clk), .reset_in(rst), .reset_pin_n_in(rpin),
        .irq_n_in(irq_n), .port_a_in(pa), .port_a_dir_in(pdir),
        .timer_flags_in(tflag), .core_in(core), .busy_out(busy), .mask_out(mask),
        .pc_out(pc), .restore_out(restore), .osc_off_out(oscoff), .clocks_off_out(clkoff),
        .mem_out(mem), .mem_rdata_in(rdata), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
        .hrdata_out(hrdata));
    cis_mem_model u_mem (.clock_in(clk), .mem_in(mem), .rdata_out(rdata));
    // ****************************************
    // bus and core tasks
    // ****************************************
    // one single ahb transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwr <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : ahb
    // one completed instruction, then wait out any sequence it starts
    task automatic instr(input cis_op_t op, input logic [12:0] nxt, tgt);
        @(posedge clk);
        core.done <= 1'b1; core.op <= op; core.pc_next <= nxt; core.target <= tgt;
        @(posedge clk);
        core.done <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk);
        #1;
        // sleep instructions stay busy on purpose; anything else must be done by now
        if (op != OP_HALT && op != OP_PAUSE) `CHK(busy, 1'b0)
    endtask : instr
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // ****************************************
    // clock, watchdog, stimulus
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // the tests need well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        rst = 1'b1; rpin = 1'b1; irq_n = 1'b1; pa = 8'hFF; pdir = 8'h00; tflag = 3'h0;
        core = '0; hsel = 1'b0; htrans = 2'h0; hwr = 1'b0; haddr = '0; hwdata = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        instr(OP_NONE, 13'h0050, 13'h0);
        `CHK(pc, 13'h05FF)
        `CHK(mask, 1'b1)
        ahb(1'b0, 32'h10, 32'h0);
        `CHK(rd, 32'h0) // unmapped
        ahb(1'b1, ADDR_CTRL, 32'h0000_0107);
        ahb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0107)
        // timer request while masked must wait
        tflag <= 3'h1;
        instr(OP_NONE, 13'h0060, 13'h0);
        ahb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[13:8], 6'h3F)
        `CHK(rd[STAT_TMR], 1'b1)
        // port source low but configured as output: no request
        pdir <= 8'h01; pa <= 8'hFE;
        repeat (6) @(posedge clk);
        ahb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[STAT_EXT], 1'b0)
        pdir <= 8'h00;
        repeat (6) @(posedge clk);
        ahb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[STAT_EXT], 1'b1)
        pa <= 8'hFF;
        core.acc <= 8'h5A;
        core.idx <= 8'hC3;
        core.hnzc <= 4'h9;
        instr(OP_CLI, 13'h0100, 13'h0);
        instr(OP_NONE, 13'h0123, 13'h0);
        `CHK(pc, 13'h05FB)
        `CHK(mask, 1'b1)
        `CHK(u_mem.mem[13'h00FF], 8'h23)
        ahb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[13:8], 6'h3A)
        `CHK(rd[STAT_EXT], 1'b0)
        instr(OP_RTI, 13'h05FC, 13'h0);
        `CHK(pc, 13'h0123)
        `CHK(mask, 1'b0)
        `CHK({restore.acc, restore.idx, restore.hnzc}, 20'h5AC39)
        `CHK(u_mem.mem[13'h00FB], 8'hF1)
        instr(OP_NONE, 13'h0200, 13'h0);
        `CHK(pc, 13'h05F9)
        instr(OP_TRAP, 13'h0300, 13'h0);
        `CHK(pc, 13'h05FD)
        instr(OP_CALL, 13'h0310, 13'h0400);
        `CHK(pc, 13'h0400)
        ahb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[13:8], 6'h33)
        instr(OP_RET, 13'h0402, 13'h0);
        `CHK(pc, 13'h0310)
        instr(OP_RSP, 13'h0311, 13'h0);
        ahb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[13:8], 6'h3F)
        // oscillator halt in edge-only mode: only a falling edge wakes it
        tflag <= 3'h0;
        ahb(1'b1, ADDR_CTRL, 32'h0000_010F);
        instr(OP_HALT, 13'h0500, 13'h0);
        `CHK({oscoff, mask}, 2'b10)
        @(posedge clk);
        irq_n <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        `CHK({oscoff, pc}, {1'b0, 13'h05FB})
        // pin still held low: edge-only mode must not request again
        instr(OP_CLI, 13'h0510, 13'h0);
        instr(OP_NONE, 13'h0600, 13'h0);
        `CHK(pc, 13'h0600)
        @(posedge clk);
        irq_n <= 1'b1;
        // clock pause: the timer keeps running and wakes it
        instr(OP_SEI, 13'h0610, 13'h0);
        instr(OP_PAUSE, 13'h0700, 13'h0);
        `CHK({clkoff, mask}, 2'b10)
        @(posedge clk);
        tflag <= 3'h4;
        repeat (16) @(posedge clk);
        #1;
        `CHK({clkoff, pc}, {1'b0, 13'h05F9})
        // reset pin in mid-run
        @(posedge clk);
        rpin <= 1'b0;
        repeat (4) @(posedge clk);
        rpin <= 1'b1;
        repeat (12) @(posedge clk);
        #1;
        `CHK({mask, pc}, {1'b1, 13'h05FF})
        ahb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[13:8], 6'h3F)
        print_verdict();
    end
endmodule : cpu_interrupt_sequencer_tb_top
